// file: src/sgs_pkg.sv
// sgs_pkg: constants for the setting group priority selector.
// assumes a 32-bit axi4-lite register bus and eight groups.
package sgs_pkg;
   localparam int SGS_GROUPS = 8;
   localparam int SGS_IDX_W = 3;
   localparam int SGS_SEL_W = 4;
   localparam int SGS_ADDR_W = 4;
   // register byte offsets
   localparam logic [SGS_ADDR_W-1:0] SGS_CTRL_ADDR = 4'h0;
   localparam logic [SGS_ADDR_W-1:0] SGS_FORCE_ADDR = 4'h4;
   localparam logic [SGS_ADDR_W-1:0] SGS_REMOTE_ADDR = 4'h8;
   localparam logic [SGS_ADDR_W-1:0] SGS_STATUS_ADDR = 4'hc;
   // ctrl fields
   localparam int SGS_CTRL_USED_LSB = 0;
   localparam int SGS_CTRL_FORCE_BIT = 3;
   localparam int SGS_CTRL_MODE_LSB = 8;
   // status fields
   localparam int SGS_ST_ACTIVE_LSB = 0;
   localparam int SGS_ST_FCFG_BIT = 4;
   localparam int SGS_ST_FPRIO_BIT = 5;
   localparam int SGS_ST_FFORCE_BIT = 6;
   localparam int SGS_ST_FORCE_BIT = 7;
   localparam int SGS_ST_REQ_LSB = 8;
   // reset values
   localparam logic [SGS_IDX_W-1:0] SGS_USED_RST = 3'h0;
   localparam logic [SGS_IDX_W-1:0] SGS_ACTIVE_RST = 3'h0;
   localparam logic [SGS_SEL_W-1:0] SGS_SEL_NONE = 4'h0;
   localparam logic [SGS_GROUPS-1:0] SGS_MODE_RST = 8'h00;
   localparam logic [SGS_GROUPS-1:0] SGS_ALL_GROUPS = 8'hff;
   // axi responses
   localparam logic [1:0] SGS_RESP_OKAY = 2'h0;
   localparam logic [1:0] SGS_RESP_SLVERR = 2'h2;
endpackage

// file: src/sgs_selector.sv
// sgs_selector: setting group priority selector with an axi4-lite slave.
// assumes request inputs synchronous to mclk_i and a single axi master.
//
// Summary of operation
// [R1] Up to eight groups; exactly one reported active at all times.
// [R2] With one group in use, group one stays active and selection idles.
// [R3] With several groups in use, requests drive which group is active.
// [R4] Each request input is a pulse or a static level, per-input mode bit.
// [R5] Fixed priority, group one highest; coinciding requests pick the highest.
// [R6] Several static levels at once activate the highest-priority one.
// [R7] A pulse-activated group stays latched until another group is requested.
// [R8] While force is enabled, input requests are ignored; forced group activates.
// [R9] Software must enable force and target group before forcing it.
// [R10] On force release, held static levels take control at once.
// [R11] Active indication is one of eight groups, group one by default.
// [R12] Forced select is none or a group, default none, acting as a pulse.
// [R13] After force release with no requests, last forced group stays active.
// [R14] Force enable defaults off, persists, and forced writes fail while off.
// [R15] Used-count setting enables one to eight groups; new ones load defaults.
// [R16] Remote request, default none, cannot beat a higher static level.
// [R17] Static level on group one blocks all other requests.
// [R18] Static level on groups two to seven blocks lower-priority requests.
// [R19] Static level on group eight blocks nothing.
// [R20] Failed request flags set and clear as events for three causes.
// [R21] Reset clears latch and force state, group one active.
// [R22] Requests for groups beyond the used count never change the group.
`timescale 1ns/1ps
module sgs_selector
   import sgs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [SGS_GROUPS-1:0] group_req_i,
   output logic [SGS_IDX_W-1:0] active_group_indication_o,
   output logic [SGS_GROUPS-1:0] active_onehot_o,
   output logic [SGS_GROUPS-1:0] group_defaults_load_o,
   output logic force_override_enable_o,
   output logic fail_not_configured_o,
   output logic fail_lower_priority_o,
   output logic fail_force_o,
   input wire logic [SGS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [SGS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // lowest set index, i.e. highest priority
   function automatic logic [SGS_IDX_W-1:0] sgs_first(input logic [SGS_GROUPS-1:0] v);
      logic [SGS_IDX_W-1:0] r;
      r = '0;
      for (int i = SGS_GROUPS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = SGS_IDX_W'(i);
         end
      end
      return r;
   endfunction

   // groups at or above a priority index
   function automatic logic [SGS_GROUPS-1:0] sgs_upto(input logic [SGS_IDX_W-1:0] idx);
      logic [SGS_GROUPS-1:0] m;
      m = '0;
      for (int i = 0; i < SGS_GROUPS; i++) begin
         m[i] = (SGS_IDX_W'(i) <= idx);
      end
      return m;
   endfunction

   function automatic logic [SGS_GROUPS-1:0] sgs_onehot(input logic [SGS_IDX_W-1:0] idx);
      return SGS_GROUPS'(1) << idx;
   endfunction

   // select names a group within the used count
   function automatic logic sgs_sel_ok(input logic [SGS_SEL_W-1:0] sel, input logic [SGS_IDX_W-1:0] top);
      logic ok;
      ok = 1'b0;
      if (sel != SGS_SEL_NONE && sel <= SGS_SEL_W'(SGS_GROUPS)) begin
         ok = (SGS_IDX_W'(sel - SGS_SEL_W'(1)) <= top);
      end
      return ok;
   endfunction

   // configuration and state
   logic [SGS_IDX_W-1:0] used_m1;
   logic force_en;
   logic force_en_q;
   logic [SGS_GROUPS-1:0] static_mode;
   logic [SGS_SEL_W-1:0] forced_group_select;
   logic [SGS_SEL_W-1:0] remote_select;
   logic force_wr;
   logic remote_wr;
   logic [SGS_GROUPS-1:0] req_q;
   logic [SGS_GROUPS-1:0] en_mask_q;
   logic [SGS_IDX_W-1:0] active;
   logic fail_cfg;
   logic fail_prio;
   logic fail_force;

   // bus handshake
   logic wr_go;
   logic rd_go;
   logic [SGS_IDX_W-1:0] wsel_idx;

   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign rd_go = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = rd_go;

   // selection terms
   logic [SGS_GROUPS-1:0] en_mask;
   logic [SGS_GROUPS-1:0] lvl;
   logic [SGS_GROUPS-1:0] stat;
   logic [SGS_GROUPS-1:0] rise;
   logic [SGS_GROUPS-1:0] acc;
   logic [SGS_GROUPS-1:0] cand;
   logic [SGS_IDX_W-1:0] hs;
   logic hs_v;
   logic force_fall;
   logic [SGS_IDX_W-1:0] force_idx;
   logic [SGS_IDX_W-1:0] rem_idx;
   logic force_ok;
   logic set_cfg;
   logic set_prio;
   logic set_force;
   logic [SGS_IDX_W-1:0] next_active;
   // any accepted change
   logic chg_ok;

   assign force_idx = SGS_IDX_W'(forced_group_select - SGS_SEL_W'(1));
   assign rem_idx = SGS_IDX_W'(remote_select - SGS_SEL_W'(1));
   assign force_fall = force_en_q && !force_en;
   assign chg_ok = |cand || force_ok;

   always_comb begin
      en_mask = sgs_upto(used_m1);                       // [R15] [R2]
      lvl = group_req_i & en_mask;                       // [R22]
      stat = lvl & static_mode;                          // [R4]
      rise = lvl & ~req_q;
      hs_v = |stat;
      hs = sgs_first(stat);                              // [R6]
      // static level blocks only lower priorities
      acc = hs_v ? (rise & sgs_upto(hs)) : rise;         // [R17] [R18] [R19]
      cand = '0;
      set_cfg = 1'b0;
      set_prio = 1'b0;
      set_force = 1'b0;
      force_ok = 1'b0;
      if (!force_en) begin
         cand = acc;
         // static retakes unless a higher pulse holds, or force just dropped
         if (hs_v && (hs < active || force_fall)) begin   // [R10]
            cand = cand | sgs_onehot(hs);
         end
         set_cfg = |(group_req_i & ~req_q & ~en_mask);
         set_prio = |(rise & ~acc);
      end                                                 // [R8]
      if (remote_wr && remote_select != SGS_SEL_NONE) begin
         if (force_en) begin
            set_force = 1'b1;
         end else if (!sgs_sel_ok(remote_select, used_m1)) begin
            set_cfg = 1'b1;
         end else if (hs_v && rem_idx > hs) begin        // [R16]
            set_prio = 1'b1;
         end else begin
            cand = cand | sgs_onehot(rem_idx);
         end
      end
      if (force_wr && forced_group_select != SGS_SEL_NONE) begin
         if (!force_en) begin
            set_force = 1'b1;                            // [R14] [R9]
         end else if (!sgs_sel_ok(forced_group_select, used_m1)) begin
            set_cfg = 1'b1;                              // [R9]
         end else begin
            force_ok = 1'b1;
         end
      end
      if (force_ok) begin
         next_active = force_idx;                        // [R8] [R12]
      end else if (|cand) begin
         next_active = sgs_first(cand);                  // [R5] [R3]
      end else if (active > used_m1) begin
         next_active = SGS_ACTIVE_RST;                   // [R22]
      end else begin
         next_active = active;                           // [R7] [R13]
      end
   end

   // active group latch
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         active <= SGS_ACTIVE_RST;                       // [R21]
      end else begin
         active <= next_active;                          // [R1]
      end
   end

   // input history and force edge
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         req_q <= '0;
         force_en_q <= 1'b0;
      end else begin
         req_q <= group_req_i;
         force_en_q <= force_en;
      end
   end

   // newly enabled groups load defaults
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         en_mask_q <= SGS_ALL_GROUPS;
         group_defaults_load_o <= '0;
      end else begin
         en_mask_q <= en_mask;
         group_defaults_load_o <= en_mask & ~en_mask_q;  // [R15]
      end
   end

   // fail flags: set on failure, cleared by next accepted change, set wins
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         fail_cfg <= 1'b0;
      end else begin
         if (set_cfg) begin
            fail_cfg <= 1'b1;                            // [R20]
         end else if (chg_ok) begin
            fail_cfg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         fail_prio <= 1'b0;
      end else begin
         if (set_prio) begin
            fail_prio <= 1'b1;                           // [R20]
         end else if (chg_ok) begin
            fail_prio <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         fail_force <= 1'b0;
      end else begin
         if (set_force) begin
            fail_force <= 1'b1;                          // [R20]
         end else if (chg_ok) begin
            fail_force <= 1'b0;
         end
      end
   end

   // register writes
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         used_m1 <= SGS_USED_RST;
         force_en <= 1'b0;                               // [R14] [R21]
         static_mode <= SGS_MODE_RST;
         forced_group_select <= SGS_SEL_NONE;            // [R12]
         remote_select <= SGS_SEL_NONE;                  // [R16]
         force_wr <= 1'b0;
         remote_wr <= 1'b0;
      end else begin
         force_wr <= 1'b0;
         remote_wr <= 1'b0;
         if (wr_go) begin
            case (s_axi_awaddr)
               SGS_CTRL_ADDR: begin
                  if (s_axi_wstrb[0]) begin
                     used_m1 <= s_axi_wdata[SGS_CTRL_USED_LSB +: SGS_IDX_W];
                     force_en <= s_axi_wdata[SGS_CTRL_FORCE_BIT];
                  end
                  if (s_axi_wstrb[1]) begin
                     static_mode <= s_axi_wdata[SGS_CTRL_MODE_LSB +: SGS_GROUPS];
                  end
               end
               SGS_FORCE_ADDR: begin
                  if (s_axi_wstrb[0]) begin
                     forced_group_select <= s_axi_wdata[SGS_SEL_W-1:0];
                     force_wr <= 1'b1;
                  end
               end
               SGS_REMOTE_ADDR: begin
                  if (s_axi_wstrb[0]) begin
                     remote_select <= s_axi_wdata[SGS_SEL_W-1:0];
                     remote_wr <= 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // write response
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SGS_RESP_OKAY;
      end else begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            case (s_axi_awaddr)
               SGS_CTRL_ADDR, SGS_FORCE_ADDR, SGS_REMOTE_ADDR: s_axi_bresp <= SGS_RESP_OKAY;
               default: s_axi_bresp <= SGS_RESP_SLVERR;
            endcase
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read data
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= SGS_RESP_OKAY;
      end else begin
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= '0;
            s_axi_rresp <= SGS_RESP_OKAY;
            case (s_axi_araddr)
               SGS_CTRL_ADDR: begin
                  s_axi_rdata[SGS_CTRL_USED_LSB +: SGS_IDX_W] <= used_m1;
                  s_axi_rdata[SGS_CTRL_FORCE_BIT] <= force_en;
                  s_axi_rdata[SGS_CTRL_MODE_LSB +: SGS_GROUPS] <= static_mode;
               end
               SGS_FORCE_ADDR: s_axi_rdata[SGS_SEL_W-1:0] <= forced_group_select;
               SGS_REMOTE_ADDR: s_axi_rdata[SGS_SEL_W-1:0] <= remote_select;
               SGS_STATUS_ADDR: begin
                  s_axi_rdata[SGS_ST_ACTIVE_LSB +: SGS_IDX_W] <= active;   // [R11]
                  s_axi_rdata[SGS_ST_FCFG_BIT] <= fail_cfg;
                  s_axi_rdata[SGS_ST_FPRIO_BIT] <= fail_prio;
                  s_axi_rdata[SGS_ST_FFORCE_BIT] <= fail_force;
                  s_axi_rdata[SGS_ST_FORCE_BIT] <= force_en;
                  s_axi_rdata[SGS_ST_REQ_LSB +: SGS_GROUPS] <= group_req_i;
               end
               default: s_axi_rresp <= SGS_RESP_SLVERR;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // outputs
   assign active_group_indication_o = active;            // [R11]
   assign active_onehot_o = sgs_onehot(active);          // [R1]
   assign force_override_enable_o = force_en;
   assign fail_not_configured_o = fail_cfg;
   assign fail_lower_priority_o = fail_prio;
   assign fail_force_o = fail_force;

endmodule

// file: tb/sgs_req_src.sv
// sgs_req_src: request sources feeding the group selector.
// assumes the bench commands levels and one-cycle pulses on mclk_i.
`timescale 1ns/1ps
module sgs_req_src
   import sgs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [SGS_GROUPS-1:0] level_i,
   input wire logic [SGS_GROUPS-1:0] pulse_i,
   output logic [SGS_GROUPS-1:0] group_req_o
);
   // levels hold, pulses give one high cycle
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         group_req_o <= 8'h00;
      end else begin
         group_req_o <= level_i | pulse_i;
      end
   end
endmodule

// file: tb/sgs_selector_asserts.sv
// sgs_selector_asserts: port checks for the group selector.
// assumes binding onto sgs_selector, one clock, async reset.
`timescale 1ns/1ps
module sgs_selector_asserts
   import sgs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [SGS_GROUPS-1:0] group_req_i,
   input wire logic [SGS_IDX_W-1:0] active_group_indication_o,
   input wire logic [SGS_GROUPS-1:0] active_onehot_o,
   input wire logic [SGS_GROUPS-1:0] group_defaults_load_o,
   input wire logic force_override_enable_o,
   input wire logic fail_not_configured_o,
   input wire logic fail_force_o,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready
);
   logic wr_take;
   assign wr_take = s_axi_awvalid && s_axi_awready;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence s_top_rise;
      $rose(group_req_i[0]) && !force_override_enable_o;
   endsequence
   sequence s_forced_quiet;
      force_override_enable_o && $past(force_override_enable_o) && !$past(wr_take) && !$past(wr_take, 2);
   endsequence
   a_onehot_match: assert property (active_onehot_o == (8'h01 << active_group_indication_o))
      else $error("onehot and index disagree");
   a_top_wins: assert property (s_top_rise ##1 !force_override_enable_o |-> active_group_indication_o == 3'h0)
      else $error("top group request lost");
   a_force_hold: assert property (s_forced_quiet |-> $stable(active_group_indication_o))
      else $error("active group moved under force");
   a_reset_vals: assert property (disable iff (1'b0) rst_i && $past(rst_i) |-> active_group_indication_o == 3'h0
      && !force_override_enable_o && !fail_force_o && !fail_not_configured_o)
      else $error("reset values wrong");
   a_load_cause: assert property (group_defaults_load_o != 8'h00 |-> $past(wr_take) || $past(wr_take, 2))
      else $error("defaults load without write");
   a_cfg_cause: assert property ($rose(fail_not_configured_o)
      |-> $past(group_req_i) != 8'h00 || $past(wr_take) || $past(wr_take, 2))
      else $error("config fail without request");
   a_ffail_cause: assert property ($rose(fail_force_o) |-> $past(wr_take) || $past(wr_take, 2))
      else $error("force fail without write");
   a_change_cause: assert property ($changed(active_group_indication_o)
      |-> $past(group_req_i) != 8'h00 || $past(wr_take) || $past(wr_take, 2))
      else $error("active group changed without cause");
endmodule
bind sgs_selector sgs_selector_asserts u_sgs_chk (.mclk_i(mclk_i), .rst_i(rst_i), .group_req_i(group_req_i),
   .active_group_indication_o(active_group_indication_o), .active_onehot_o(active_onehot_o),
   .group_defaults_load_o(group_defaults_load_o), .force_override_enable_o(force_override_enable_o),
   .fail_not_configured_o(fail_not_configured_o), .fail_force_o(fail_force_o),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready));

// file: tb/sgs_selector_tb.sv
// sgs_selector_tb: self-checking bench for the group selector.
// assumes sgs_req_src as request source and the bound checker.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module sgs_selector_tb
   import sgs_pkg::*;
;
   logic mclk_i;
   logic rst_i = 1'b1;
   logic [7:0] lv = 8'h00, pl = 8'h00, group_req_i, onehot, load, seen_load;
   logic [2:0] act;
   logic force_en, fcfg, fprio, fforce, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   int num_errors = 0, total_checks = 0;
   sgs_req_src u_src (.mclk_i, .rst_i, .level_i(lv), .pulse_i(pl), .group_req_o(group_req_i));
   sgs_selector dut (.mclk_i, .rst_i, .group_req_i, .active_group_indication_o(act), .active_onehot_o(onehot),
      .group_defaults_load_o(load), .force_override_enable_o(force_en), .fail_not_configured_o(fcfg),
      .fail_lower_priority_o(fprio), .fail_force_o(fforce), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   always @(posedge mclk_i) seen_load <= seen_load | load;
   task automatic close_out;
      if (num_errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge mclk_i); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge mclk_i); while (s_axi_bvalid !== 1'b1);
      `CHK("bresp", SGS_RESP_OKAY, s_axi_bresp)
      s_axi_bready <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk_i); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk_i); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      `CHK("rresp", SGS_RESP_OKAY, s_axi_rresp)
      s_axi_rready <= 1'b0;
   endtask
   task automatic drive(input logic [7:0] l, input logic [7:0] p);
      @(posedge mclk_i);
      lv <= l;
      pl <= p;
      @(posedge mclk_i);
      pl <= 8'h00;
      repeat (2) @(posedge mclk_i);
      #1;
   endtask
   task automatic t_reset;
      logic [31:0] d;
      `CHK("active", 3'h0, act)
      `CHK("onehot", 8'h01, onehot)
      `CHK("flags", 4'h0, {force_en, fcfg, fprio, fforce})
      rd(SGS_CTRL_ADDR, d);
      `CHK("ctrl", 32'h0000_0000, d)
      rd(SGS_FORCE_ADDR, d);
      `CHK("force sel", SGS_SEL_NONE, d[3:0])
      rd(SGS_REMOTE_ADDR, d);
      `CHK("remote sel", SGS_SEL_NONE, d[3:0])
   endtask
   task automatic t_single;
      drive(8'h00, 8'h04);
      `CHK("active", 3'h0, act)
      `CHK("fail cfg", 1'b1, fcfg)
   endtask
   task automatic t_static;
      logic [7:0] l [9] = '{8'h14, 8'h15, 8'h17, 8'h00, 8'h10, 8'h50, 8'h52, 8'h80, 8'ha0};
      logic [2:0] e [9] = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h4, 3'h4, 3'h1, 3'h7, 3'h5};
      logic [31:0] d;
      wr(SGS_CTRL_ADDR, 32'h0000_ff07);
      wr(SGS_CTRL_ADDR, 32'h0000_ff00);
      seen_load = 8'h00;
      wr(SGS_CTRL_ADDR, 32'h0000_ff07);
      `CHK("defaults load", 8'hfe, seen_load)
      for (int i = 0; i < 9; i++) begin
         drive(l[i], 8'h00);
         `CHK("active", e[i], act)
         if (i == 2 || i == 5) `CHK("fail prio", 1'b1, fprio)
      end
      rd(SGS_STATUS_ADDR, d);
      `CHK("status", 11'h505, {d[15:8], d[2:0]})
      drive(8'h00, 8'h00);
   endtask
   task automatic t_pulse;
      wr(SGS_CTRL_ADDR, 32'h0000_0007);
      drive(8'h00, 8'h08);
      drive(8'h00, 8'h00);
      `CHK("active", 3'h3, act)
      drive(8'h00, 8'h20);
      `CHK("active", 3'h5, act)
   endtask
   task automatic t_remote;
      wr(SGS_CTRL_ADDR, 32'h0000_0207);
      drive(8'h02, 8'h00);
      wr(SGS_REMOTE_ADDR, 32'h0000_0005);
      `CHK("active", 3'h1, act)
      wr(SGS_REMOTE_ADDR, 32'h0000_0001);
      `CHK("active", 3'h0, act)
      drive(8'h00, 8'h00);
   endtask
   task automatic t_force;
      wr(SGS_CTRL_ADDR, 32'h0000_0807);
      wr(SGS_FORCE_ADDR, 32'h0000_0003);
      `CHK("force refused", 4'h1, {act, fforce})
      wr(SGS_CTRL_ADDR, 32'h0000_080f);
      wr(SGS_FORCE_ADDR, 32'h0000_0002);
      `CHK("forced", 4'h3, {act, force_en})
      drive(8'h08, 8'h01);
      `CHK("active", 3'h1, act)
      wr(SGS_CTRL_ADDR, 32'h0000_0807);
      `CHK("released", 4'h6, {act, force_en})
      drive(8'h00, 8'h00);
      wr(SGS_CTRL_ADDR, 32'h0000_080f);
      wr(SGS_FORCE_ADDR, 32'h0000_0006);
      wr(SGS_CTRL_ADDR, 32'h0000_0807);
      `CHK("active", 3'h5, act)
      wr(SGS_CTRL_ADDR, 32'h0000_080f);
      wr(SGS_FORCE_ADDR, 32'h0000_0009);
      `CHK("bad force sel", 4'hb, {act, fcfg})
   endtask
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   initial begin
      #20000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      t_reset();
      t_single();
      t_static();
      t_pulse();
      t_remote();
      t_force();
      close_out();
   end
endmodule
